// >>> logic/fe_defines.svh
`ifndef FE_DEFINES_SVH
`define FE_DEFINES_SVH
// ---------------------------------------------
// register offsets
// ---------------------------------------------
`define FE_ADDR_CTRL      12'h000
`define FE_ADDR_BANK0     12'h004
`define FE_ADDR_BANK1     12'h008
`define FE_ADDR_MAP       12'h00C
`define FE_ADDR_STATUS    12'h010
// ---------------------------------------------
// field positions
// ---------------------------------------------
`define FE_CTRL_MODE4     0
`define FE_CTRL_ACT_LO    1
`define FE_CTRL_BANK      3
`define FE_BANK_RESO_LO   0
`define FE_BANK_SPEED_LO  8
`define FE_BANK_RESP_LO   16
`define FE_BANK_ILOCK     20
`define FE_MAP_MSG_LO     0
`define FE_MAP_IO1_LO     2
`define FE_MAP_AUX_LO     4
`define FE_ST_FAULT       0
`define FE_ST_SAFE        1
`define FE_ST_LOCK        2
`define FE_ST_BIND        3
`define FE_ST_WFA         4
`define FE_ST_WFB         5
`define FE_ST_SEL_LO      8
// ---------------------------------------------
// reset values and limits
// ---------------------------------------------
`define FE_CTRL_RST       32'h0000_0000
`define FE_BANK_RST       32'h0011_0000
`define FE_MAP_RST        32'h0000_0018
`define FE_NPAIRS         4'hA
`define FE_NPAIRS_OVL     4'h5
// ---------------------------------------------
// timing
// ---------------------------------------------
`define FE_CLK_KHZ        200000
`define FE_RELEASE_MIN_MS 120
`define FE_RELEASE_MAX_MS 4000
`define FE_OVL_TIME_US    10
`define FE_OVL_CYC        ((`FE_OVL_TIME_US * `FE_CLK_KHZ) / 1000)
`endif

// >>> logic/fe_field_eval.sv
// Added by the designer: the placing of the registers and the APB slave port.
`include "fe_defines.svh"
`default_nettype none
module fe_field_eval
	import fe_pkg::*;
#(
	parameter int unsigned RELEASE_MIN_CYC =
		`FE_RELEASE_MIN_MS * `FE_CLK_KHZ,
	parameter int unsigned RELEASE_MAX_CYC =
		`FE_RELEASE_MAX_MS * `FE_CLK_KHZ
) (
	input  wire logic        pclk,                    // clock
	input  wire logic        presetn,                 // async reset
	input  wire logic [11:0] paddr,                   // apb address
	input  wire logic        psel,                    // apb select
	input  wire logic        penable,                 // apb enable
	input  wire logic        pwrite,                  // apb write
	input  wire logic [31:0] pwdata,                  // apb wdata
	output logic      [31:0] prdata,                  // apb rdata
	output logic             pready,                  // apb ready
	output logic             pslverr,                 // apb error
	input  wire logic [3:0]  field_sel,               // pair select
	input  wire logic        scan_valid,              // scan done
	input  wire logic [9:0]  prot_viol_a,             // A prot per pair
	input  wire logic [9:0]  prot_viol_b,             // B prot per pair
	input  wire logic [9:0]  warn_viol_a,             // A warn per pair
	input  wire logic [9:0]  warn_viol_b,             // B warn per pair
	input  wire logic        reset_button,            // release button
	output logic             safety_output_a,         // safety out
	output logic             message_output,          // mapped out
	output logic             io_switching_output_one, // mapped out
	output logic             aux_switching_output,    // mapped out
	output logic      [7:0]  resolution_mm,           // active reso
	output logic      [7:0]  max_speed,               // active speed
	output logic             change_fault             // fault flag
);
	// ---------------------------------------------
	// functions
	// ---------------------------------------------
	function automatic logic bit_at(input logic [9:0] v,
	                                input logic [3:0] i);
		// out-of-range index reads as violated: fail safe
		bit_at = (i < `FE_NPAIRS) ? v[i] : 1'b1;
	endfunction

	function automatic logic [7:0] reso_of(input logic [2:0] c);
		case (c)
			3'h0:    reso_of = 8'h1E;
			3'h1:    reso_of = 8'h28;
			3'h2:    reso_of = 8'h32;
			3'h3:    reso_of = 8'h3C;
			3'h4:    reso_of = 8'h46;
			3'h5:    reso_of = 8'h96;
			default: reso_of = 8'h00;
		endcase
	endfunction

	// ---------------------------------------------
	// declarations
	// ---------------------------------------------
	logic [31:0] ctrl_r;
	logic [31:0] bank0_r;
	logic [31:0] bank1_r;
	logic [31:0] map_r;
	logic [31:0] bank_act_r;
	logic [31:0] rdata_nxt;
	logic        addr_ok;
	logic        wr_en;
	logic        setup;
	logic        mode4;
	fe_act_t     act;
	logic [3:0]  resp_eff;
	logic        ilock;
	logic [3:0]  sel;
	logic        sel_bad;
	logic        fault_r;
	logic [3:0]  prev_sel_r;
	logic [3:0]  old_sel_r;
	logic [11:0] ovl_cnt_r;
	logic        ovl_on;
	logic        va;
	logic        vb;
	logic        wa;
	logic        wb;
	logic        first_scan_r;
	logic [3:0]  vcnt_r;
	logic        bind_r;
	logic        wfa_r;
	logic        wfb_r;
	logic        trip;
	logic        ok;
	logic [29:0] press_cnt_r;
	logic        rel_pulse;
	fe_state_t   st_r;
	logic [3:0]  sigs;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ---------------------------------------------
	// apb slave
	// ---------------------------------------------
	assign setup   = psel & ~penable;
	assign wr_en   = psel & penable & pwrite & addr_ok;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	always_comb begin
		addr_ok   = 1'b1;
		rdata_nxt = 32'h0000_0000;
		case (paddr)
			`FE_ADDR_CTRL:  rdata_nxt = ctrl_r;
			`FE_ADDR_BANK0: rdata_nxt = bank0_r;
			`FE_ADDR_BANK1: rdata_nxt = bank1_r;
			`FE_ADDR_MAP:   rdata_nxt = map_r;
			`FE_ADDR_STATUS: begin
				rdata_nxt[`FE_ST_FAULT] = fault_r;
				rdata_nxt[`FE_ST_SAFE]  = safety_output_a;
				rdata_nxt[`FE_ST_LOCK]  = st_r == FE_LOCKED;
				rdata_nxt[`FE_ST_BIND]  = bind_r;
				rdata_nxt[`FE_ST_WFA]   = wfa_r;
				rdata_nxt[`FE_ST_WFB]   = wfb_r;
				rdata_nxt[`FE_ST_SEL_LO +: 4] = sel;
			end
			default: addr_ok = 1'b0;
		endcase
	end

	// read data is captured in setup so it is a flop at access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup)
			prdata <= rdata_nxt;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r  <= `FE_CTRL_RST;
			bank0_r <= `FE_BANK_RST;
			bank1_r <= `FE_BANK_RST;
			map_r   <= `FE_MAP_RST;
		end else if (wr_en) begin
			case (paddr)
				`FE_ADDR_CTRL:  ctrl_r  <= pwdata;
				`FE_ADDR_BANK0: bank0_r <= pwdata;
				`FE_ADDR_BANK1: bank1_r <= pwdata;
				`FE_ADDR_MAP:   map_r   <= pwdata;
				default: ;
			endcase
		end
	end

	// bank parameters take effect only on a control write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			bank_act_r <= `FE_BANK_RST;
		else if (wr_en && paddr == `FE_ADDR_CTRL)
			bank_act_r <= pwdata[`FE_CTRL_BANK] ? bank1_r : bank0_r;
	end

	// ---------------------------------------------
	// configuration decode
	// ---------------------------------------------
	assign mode4 = ctrl_r[`FE_CTRL_MODE4];
	assign act   = fe_act_t'(ctrl_r[`FE_CTRL_ACT_LO +: 2]);
	assign ilock = bank_act_r[`FE_BANK_ILOCK];
	assign resp_eff = (bank_act_r[`FE_BANK_RESP_LO +: 4] == 4'h0) ?
		4'h1 : bank_act_r[`FE_BANK_RESP_LO +: 4];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resolution_mm <= 8'h00;
			max_speed     <= 8'h00;
		end else begin
			resolution_mm <= reso_of(bank_act_r[`FE_BANK_RESO_LO +: 3]);
			max_speed <= bank_act_r[`FE_BANK_SPEED_LO +: 8];
		end
	end

	// ---------------------------------------------
	// field pair selection
	// ---------------------------------------------
	assign sel = (act == FE_ACT_FIXED) ? 4'h0 : field_sel;

	assign sel_bad = (act == FE_ACT_BAD) |
		(mode4 & act == FE_ACT_OVL5) |
		(act == FE_ACT_OVL5 & field_sel >= `FE_NPAIRS_OVL) |
		(act == FE_ACT_FIX10 & field_sel >= `FE_NPAIRS) |
		(reso_of(bank_act_r[`FE_BANK_RESO_LO +: 3]) == 8'h00);

	// a new fault wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fault_r <= 1'b0;
		else if (sel_bad)
			fault_r <= 1'b1;
		else if (wr_en && paddr == `FE_ADDR_STATUS &&
		         pwdata[`FE_ST_FAULT])
			fault_r <= 1'b0;
	end
	assign change_fault = fault_r;

	// overlapped mode keeps the previous pair watched a while
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_sel_r <= 4'h0;
			old_sel_r  <= 4'h0;
			ovl_cnt_r  <= 12'h000;
		end else begin
			prev_sel_r <= sel;
			if (act == FE_ACT_OVL5 && sel != prev_sel_r) begin
				old_sel_r <= prev_sel_r;
				ovl_cnt_r <= 12'(`FE_OVL_CYC);
			end else if (ovl_cnt_r != 12'h000)
				ovl_cnt_r <= ovl_cnt_r - 12'h001;
		end
	end
	assign ovl_on = ovl_cnt_r != 12'h000;

	// A and B share the pair index; only A also watches the old pair while overlap runs
	assign va = bit_at(prot_viol_a, sel) |
		(ovl_on & bit_at(prot_viol_a, old_sel_r));
	assign vb = bit_at(prot_viol_b, sel);
	assign wa = bit_at(warn_viol_a, sel) |
		(ovl_on & bit_at(warn_viol_a, old_sel_r));
	assign wb = bit_at(warn_viol_b, sel);

	// ---------------------------------------------
	// scan evaluation
	// ---------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_scan_r <= 1'b0;
			vcnt_r       <= 4'h0;
			bind_r       <= 1'b0;
			wfa_r        <= 1'b0;
			wfb_r        <= 1'b0;
		end else if (scan_valid) begin
			first_scan_r <= 1'b1;
			if (!va)
				vcnt_r <= 4'h0;
			else if (vcnt_r != 4'hF)
				vcnt_r <= vcnt_r + 4'h1;
			bind_r <= mode4 & vb;
			wfa_r  <= wa;
			wfb_r  <= mode4 & wb;
		end
	end

	assign trip = vcnt_r >= resp_eff;
	assign ok   = first_scan_r & ~fault_r & ~sel_bad &
		(vcnt_r == 4'h0);

	// ---------------------------------------------
	// release button timing
	// ---------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			press_cnt_r <= 30'h0000_0000;
		else if (!reset_button)
			press_cnt_r <= 30'h0000_0000;
		else if (press_cnt_r != 30'h3FFF_FFFF)
			press_cnt_r <= press_cnt_r + 30'h0000_0001;
	end

	// too short or too long a press is ignored
	assign rel_pulse = ~reset_button & (press_cnt_r != 30'h0000_0000) &
		({2'b00, press_cnt_r} >= RELEASE_MIN_CYC) &
		({2'b00, press_cnt_r} <= RELEASE_MAX_CYC);

	// ---------------------------------------------
	// start-up state machine
	// ---------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st_r <= FE_LOCKED;
		else begin
			case (st_r)
				FE_LOCKED:
					if (ok && (!ilock || rel_pulse))
						st_r <= FE_ON;
				FE_OFF:
					if (ok)
						st_r <= FE_ON;
				FE_ON:
					if (trip || fault_r || sel_bad)
						st_r <= FE_OFF;
				default: st_r <= FE_LOCKED;
			endcase
		end
	end
	assign safety_output_a = st_r[2];

	// ---------------------------------------------
	// output mapping
	// ---------------------------------------------
	// safety output is never remapped: only indications move
	assign sigs = {fault_r, wfb_r, wfa_r, bind_r};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			message_output          <= 1'b0;
			io_switching_output_one <= 1'b0;
			aux_switching_output    <= 1'b0;
		end else begin
			message_output <= sigs[map_r[`FE_MAP_MSG_LO +: 2]];
			io_switching_output_one <=
				sigs[map_r[`FE_MAP_IO1_LO +: 2]];
			aux_switching_output <= sigs[map_r[`FE_MAP_AUX_LO +: 2]];
		end
	end

	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	a_fault_forces_off: assert property (
		fault_r |=> !safety_output_a)
		else $error("safety on while fault set");
	a_trip_drops_out: assert property (
		(st_r == FE_ON && trip) |=> !safety_output_a)
		else $error("safety stayed on after trip");
	a_b_keeps_on: assert property (
		(st_r == FE_ON && ok) |=> safety_output_a)
		else $error("safety dropped with A clear");
	a_b_indicates: assert property (
		(scan_valid && mode4 && vb) |=> bind_r)
		else $error("B violation not indicated");
	a_single_b_quiet: assert property (
		(scan_valid && !mode4) |=> !bind_r && !wfb_r)
		else $error("B signals active in single mode");
	a_lock_holds: assert property (
		(st_r == FE_LOCKED && ilock && !rel_pulse) |=> !safety_output_a)
		else $error("interlock released without press");
	a_short_press: assert property (
		(st_r == FE_LOCKED && ilock && !reset_button &&
		 {2'b00, press_cnt_r} < RELEASE_MIN_CYC) |=> !safety_output_a)
		else $error("short press released interlock");
	a_auto_start: assert property (
		(st_r == FE_LOCKED && !ilock && ok) |=> safety_output_a)
		else $error("auto start did not enable");
	a_first_scan: assert property (
		!first_scan_r |-> !safety_output_a)
		else $error("safety on before first scan");
	a_bank_latch: assert property (
		(wr_en && paddr == `FE_ADDR_CTRL && !pwdata[`FE_CTRL_BANK])
		|=> bank_act_r == $past(bank0_r))
		else $error("bank parameters not latched");
	a_resp_bound: assert property (
		(st_r == FE_ON && scan_valid && va && vcnt_r == resp_eff - 4'h1)
		|=> ##1 !safety_output_a)
		else $error("switch off later than response");

	c_release: cover property (
		st_r == FE_LOCKED && ilock ##1 st_r == FE_ON);
	c_restart: cover property (st_r == FE_OFF ##1 st_r == FE_ON);
	c_fault: cover property ($rose(fault_r));
	c_overlap: cover property (ovl_on && va);
endmodule
`default_nettype wire

// >>> logic/fe_pkg.sv
`default_nettype none
package fe_pkg;
	typedef enum logic [2:0] {
		FE_LOCKED = 3'h1,
		FE_OFF    = 3'h2,
		FE_ON     = 3'h4
	} fe_state_t;
	typedef enum logic [1:0] {
		FE_ACT_FIXED = 2'h0,
		FE_ACT_OVL5  = 2'h1,
		FE_ACT_FIX10 = 2'h2,
		FE_ACT_BAD   = 2'h3
	} fe_act_t;
	typedef enum logic [1:0] {
		FE_SIG_BIND  = 2'h0,
		FE_SIG_WFA   = 2'h1,
		FE_SIG_WFB   = 2'h2,
		FE_SIG_FAULT = 2'h3
	} fe_sig_t;
endpackage
`default_nettype wire

// >>> tb/fe_control_model.sv
`default_nettype none
module fe_control_model (
	input  wire logic       pclk,        // clock
	output logic      [3:0] field_sel,   // pair select
	output logic            scan_valid,  // scan done
	output logic      [9:0] prot_viol_a, // A prot per pair
	output logic      [9:0] prot_viol_b, // B prot per pair
	output logic      [9:0] warn_viol_a, // A warn per pair
	output logic      [9:0] warn_viol_b, // B warn per pair
	output logic            reset_button // release button
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		field_sel = 4'h0;
		scan_valid = 1'b0;
		{prot_viol_a, prot_viol_b, warn_viol_a, warn_viol_b} = 40'h0;
		reset_button = 1'b0;
	end
	// -----------------------------------------
	// one completed scan
	// -----------------------------------------
	// stale outside the scan pulse: show the inverse
	task automatic scan(input logic [3:0] s, input logic [9:0] a, b, c, d);
		logic [39:0] v;
		v = {a, b, c, d};
		@(posedge pclk);
		field_sel <= s;
		@(posedge pclk);
		scan_valid <= 1'b1;
		{prot_viol_a, prot_viol_b, warn_viol_a, warn_viol_b} <= v;
		@(posedge pclk);
		scan_valid <= 1'b0;
		{prot_viol_a, prot_viol_b, warn_viol_a, warn_viol_b} <= ~v;
	endtask
	// -----------------------------------------
	// operator button, held n cycles
	// -----------------------------------------
	task automatic press(input int n);
		@(posedge pclk);
		reset_button <= 1'b1;
		repeat (n) @(posedge pclk);
		reset_button <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> tb/fe_field_eval_tb.sv
`include "fe_defines.svh"
`default_nettype none
module fe_field_eval_tb
	import fe_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic        serr, scan_valid, reset_button;
	logic [3:0]  field_sel;
	logic [9:0]  pva, pvb, wva, wvb;
	logic        safe, msg, io1, aux, fault;
	logic [7:0]  reso, speed;
	int          num_errors = 0;
	int          comparisons = 0;
	logic [7:0]  reso_tab [6] = '{8'h1E, 8'h28, 8'h32, 8'h3C, 8'h46, 8'h96};
	// -----------------------------------------
	// design and partner
	// -----------------------------------------
	fe_field_eval #(.RELEASE_MIN_CYC(12), .RELEASE_MAX_CYC(400))
	fe_field_eval_i (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.field_sel(field_sel), .scan_valid(scan_valid),
		.prot_viol_a(pva), .prot_viol_b(pvb), .warn_viol_a(wva),
		.warn_viol_b(wvb), .reset_button(reset_button),
		.safety_output_a(safe), .message_output(msg),
		.io_switching_output_one(io1), .aux_switching_output(aux),
		.resolution_mm(reso), .max_speed(speed), .change_fault(fault)
	);
	fe_control_model fe_control_model_i (
		.pclk(pclk), .field_sel(field_sel), .scan_valid(scan_valid),
		.prot_viol_a(pva), .prot_viol_b(pvb), .warn_viol_a(wva),
		.warn_viol_b(wvb), .reset_button(reset_button)
	);
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// -----------------------------------------
	// bus and check tasks
	// -----------------------------------------
	task automatic tally_and_finish();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %0t got %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w,
			input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees ready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// scan, then let state and mapped outputs land
	task automatic sc(input logic [3:0] s, input logic [9:0] a, b, c, d);
		fe_control_model_i.scan(s, a, b, c, d);
		repeat (3) @(posedge pclk);
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		tally_and_finish();
	end
	// -----------------------------------------
	// sequence
	// -----------------------------------------
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = 47'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		check(32'(safe), 32'h0);
		apb(`FE_ADDR_STATUS, 1'b0, 32'h0);
		check(32'(q[`FE_ST_LOCK]), 32'h1);
		apb(`FE_ADDR_BANK0, 1'b0, 32'h0);
		check(q, 32'h0011_0000);
		apb(`FE_ADDR_MAP, 1'b0, 32'h0);
		check(q, 32'h0000_0018);
		sc(4'h0, 10'h0, 10'h0, 10'h0, 10'h0);
		check(32'(safe), 32'h0);
		fe_control_model_i.press(5);
		repeat (3) @(posedge pclk);
		check(32'(safe), 32'h0);
		fe_control_model_i.press(20);
		repeat (3) @(posedge pclk);
		check(32'(safe), 32'h1);
		sc(4'h0, 10'h1, 10'h0, 10'h0, 10'h0);
		check(32'(safe), 32'h0);
		sc(4'h0, 10'h0, 10'h0, 10'h0, 10'h0);
		check(32'(safe), 32'h1);
		for (int i = 0; i < 6; i++) begin
			apb(`FE_ADDR_BANK0, 1'b1, 32'h0001_4000 | (i << 8) | i);
			apb(`FE_ADDR_CTRL, 1'b1, 32'h0);
			repeat (3) @(posedge pclk);
			check(32'(reso), 32'(reso_tab[i]));
			check(32'(speed), 32'h40 | i);
		end
		// three consecutive violated scans before the output may drop
		apb(`FE_ADDR_BANK0, 1'b1, 32'h0003_0000);
		apb(`FE_ADDR_CTRL, 1'b1, 32'h0);
		sc(4'h0, 10'h1, 10'h0, 10'h0, 10'h0);
		sc(4'h0, 10'h1, 10'h0, 10'h0, 10'h0);
		check(32'(safe), 32'h1);
		sc(4'h0, 10'h1, 10'h0, 10'h0, 10'h0);
		check(32'(safe), 32'h0);
		sc(4'h0, 10'h0, 10'h0, 10'h0, 10'h0);
		check(32'(safe), 32'h1);
		apb(`FE_ADDR_BANK0, 1'b1, 32'h0001_0000);
		apb(`FE_ADDR_CTRL, 1'b1, 32'h1);
		sc(4'h0, 10'h0, 10'h1, 10'h0, 10'h0);
		check(32'(safe), 32'h1);
		check(32'(msg), 32'h1);
		apb(`FE_ADDR_STATUS, 1'b0, 32'h0);
		check(32'(q[`FE_ST_BIND]), 32'h1);
		sc(4'h0, 10'h0, 10'h0, 10'h1, 10'h1);
		check({29'h0, msg, io1, aux}, 32'h3);
		apb(`FE_ADDR_CTRL, 1'b1, 32'h5);
		sc(4'h9, 10'h0, 10'h200, 10'h0, 10'h0);
		check({30'h0, safe, msg}, 32'h3);
		sc(4'h9, 10'h200, 10'h0, 10'h0, 10'h0);
		check(32'(safe), 32'h0);
		sc(4'h9, 10'h0, 10'h0, 10'h0, 10'h0);
		apb(`FE_ADDR_BANK1, 1'b1, 32'h0001_0005);
		apb(`FE_ADDR_CTRL, 1'b1, 32'h8);
		repeat (3) @(posedge pclk);
		check(32'(reso), 32'h96);
		apb(`FE_ADDR_CTRL, 1'b1, 32'h4);
		sc(4'h7, 10'h080, 10'h0, 10'h0, 10'h0);
		check(32'(safe), 32'h0);
		sc(4'h7, 10'h0, 10'h0, 10'h0, 10'h0);
		check(32'(safe), 32'h1);
		sc(4'hA, 10'h0, 10'h0, 10'h0, 10'h0);
		check({30'h0, fault, safe}, 32'h2);
		sc(4'h2, 10'h0, 10'h0, 10'h0, 10'h0);
		apb(`FE_ADDR_CTRL, 1'b1, 32'h2);
		apb(`FE_ADDR_STATUS, 1'b1, 32'h1);
		sc(4'h2, 10'h0, 10'h0, 10'h0, 10'h0);
		check({30'h0, fault, safe}, 32'h1);
		sc(4'h5, 10'h0, 10'h0, 10'h0, 10'h0);
		check({30'h0, fault, safe}, 32'h2);
		apb(12'h020, 1'b0, 32'h0);
		check({serr, q[30:0]}, 32'h8000_0000);
		// fault routed to the message output
		sc(4'h2, 10'h0, 10'h0, 10'h0, 10'h0);
		apb(`FE_ADDR_MAP, 1'b1, 32'h3);
		repeat (2) @(posedge pclk);
		check(32'(msg), 32'h1);
		// each of three bad settings keeps the fault set against a clear; the fourth, good setting lets it clear
		for (int i = 0; i < 4; i++) begin
			apb(`FE_ADDR_BANK0, 1'b1,
				(i == 2) ? 32'h0001_0006 : 32'h0001_0000);
			apb(`FE_ADDR_CTRL, 1'b1,
				(i == 0) ? 32'h6 : (i == 1) ? 32'h3 : 32'h0);
			apb(`FE_ADDR_STATUS, 1'b1, 32'h1);
			apb(`FE_ADDR_STATUS, 1'b0, 32'h0);
			check(32'(q[`FE_ST_FAULT]), 32'(i != 3));
		end
		// old pair still watched just after an overlapped change
		apb(`FE_ADDR_CTRL, 1'b1, 32'h2);
		sc(4'h1, 10'h0, 10'h0, 10'h0, 10'h0);
		sc(4'h3, 10'h002, 10'h0, 10'h0, 10'h0);
		check(32'(safe), 32'h0);
		// second power-up: long press ignored, then a valid release
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		check(32'(safe), 32'h0);
		sc(4'h0, 10'h0, 10'h0, 10'h0, 10'h0);
		fe_control_model_i.press(450);
		repeat (3) @(posedge pclk);
		check(32'(safe), 32'h0);
		fe_control_model_i.press(20);
		repeat (3) @(posedge pclk);
		check(32'(safe), 32'h1);
		// third power-up with an automatic start bank
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(`FE_ADDR_BANK0, 1'b1, 32'h0001_0000);
		apb(`FE_ADDR_CTRL, 1'b1, 32'h0);
		check(32'(safe), 32'h0);
		sc(4'h0, 10'h0, 10'h0, 10'h0, 10'h0);
		check(32'(safe), 32'h1);
		tally_and_finish();
	end
endmodule
`default_nettype wire
